/* File: verilog/power_mgmt_control_status_pkg.sv */
// constants of the power management control/status block
// assumes an apb slave at 25 mhz with 32-bit data
package power_mgmt_control_status_pkg;

  // ----------------------------------------
  // bus shape
  // ----------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;

  // ----------------------------------------
  // register byte addresses
  // ----------------------------------------
  localparam logic [11:0] OFF_POWER_MGMT_CONTROL_STATUS = 12'h000;
  localparam logic [11:0] OFF_PWR_CAP = 12'h004;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h008;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h00C;

  // ----------------------------------------
  // control/status field positions
  // ----------------------------------------
  localparam int WAKE_STATUS_BIT = 15;
  localparam int SCALE_LSB = 13;
  localparam int SCALE_W = 2;
  localparam int SELECT_LSB = 9;
  localparam int SELECT_W = 4;
  localparam int WAKE_ENABLE_BIT = 8;
  localparam int PSTATE_LSB = 0;
  localparam int PSTATE_W = 2;

  // ----------------------------------------
  // capability field positions
  // ----------------------------------------
  localparam int CAP_D3COLD_BIT = 15;
  localparam int CAP_D2_BIT = 10;
  localparam int CAP_D1_BIT = 9;

  // ----------------------------------------
  // power state encoding and reset values
  // ----------------------------------------
  localparam logic [1:0] PSTATE_D0 = 2'h0;
  localparam logic [1:0] PSTATE_D1 = 2'h1;
  localparam logic [1:0] PSTATE_D2 = 2'h2;
  localparam logic [1:0] PSTATE_D3HOT = 2'h3;
  localparam logic [1:0] SCALE_NONE = 2'h0;
  localparam logic [3:0] SELECT_NONE = 4'h0;

  // ----------------------------------------
  // interrupt status bits
  // ----------------------------------------
  localparam int IRQ_W = 3;
  localparam int IRQ_WAKE_BIT = 0;
  localparam int IRQ_STATE_BIT = 1;
  localparam int IRQ_REJECT_BIT = 2;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

endpackage

/* File: verilog/power_mgmt_control_status_sticky_bits.sv */
// a row of sticky flags: set by hardware, cleared by a pulse
// assumes set and clear are one-cycle pulses on the same clock
`timescale 1ns/1ps
`default_nettype none

module power_mgmt_control_status_sticky_bits #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  input wire logic zero,
  output logic [W-1:0] q
);

  // ----------------------------------------
  // flag storage
  // ----------------------------------------
  // set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else if (zero) begin
      q <= '0;
    end else begin
      q <= (q & ~clr) | set;
    end
  end

endmodule

`default_nettype wire

/* File: verilog/power_mgmt_control_status_ctrl.sv */
// power management control/status register bank behind an apb slave
// assumes pclk at 25 mhz, straps steady around reset, aux_por_n from
// the auxiliary supply so sticky wake state can outlive presetn
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - a wake event sets the wake status flag whatever the enable bit holds.
// - writing one to the wake status flag clears it and releases the wake pin; zero does nothing.
// - wake status clears at reset without cold wake support, else survives reset for software.
// - the wake pin may assert only while the wake enable bit is one.
// - wake enable clears at reset without cold wake support, else survives reset for software.
// - the read-only scale field reads 00b since no data register exists.
// - the select field reads zero since no data register exists.
// - the power state field reads the current state and takes writes, 0 to 3 for D0 to D3hot.
// - a write asking for an unsupported state completes but only sets the reject interrupt flag.
// - capability bit fifteen shows cold wake support and picks sticky or zeroed event bits.
module power_mgmt_control_status_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic aux_por_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [power_mgmt_control_status_pkg::ADDR_W-1:0] paddr,
  input wire logic [power_mgmt_control_status_pkg::DATA_W-1:0] pwdata,
  input wire logic [power_mgmt_control_status_pkg::STRB_W-1:0] pstrb,
  output logic pready,
  output logic pslverr,
  output logic [power_mgmt_control_status_pkg::DATA_W-1:0] prdata,
  input wire logic wake_d3cold_strap,
  input wire logic d1_support_strap,
  input wire logic d2_support_strap,
  input wire logic wake_event,
  output logic wake_out_n,
  output logic [power_mgmt_control_status_pkg::PSTATE_W-1:0] power_state,
  output logic irq
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic reset_pulse;
  logic zero_sticky;
  logic cap_d3cold;
  logic cap_d1;
  logic cap_d2;
  logic wake_event_status;
  logic wake_event_enable;
  logic [power_mgmt_control_status_pkg::IRQ_W-1:0] irq_status;
  logic [power_mgmt_control_status_pkg::IRQ_W-1:0] irq_mask;
  logic [power_mgmt_control_status_pkg::IRQ_W-1:0] irq_set;
  logic [power_mgmt_control_status_pkg::IRQ_W-1:0] irq_clr;
  logic setup_phase;
  logic access_done;
  logic wr_done;
  logic hit_power_mgmt_control_status;
  logic hit_cap;
  logic hit_irq_status;
  logic hit_irq_mask;
  logic addr_ok;
  logic wr_power_mgmt_control_status;
  logic wr_power_mgmt_control_status_hi;
  logic wr_power_mgmt_control_status_lo;
  logic [power_mgmt_control_status_pkg::PSTATE_W-1:0] req_state;
  logic req_state_ok;
  logic power_mgmt_control_status_accept;
  logic wake_clear;
  logic state_change;
  logic state_reject;
  logic [15:0] power_mgmt_control_status_view;
  logic [15:0] cap_view;
  logic [power_mgmt_control_status_pkg::DATA_W-1:0] next_prdata;

  // ----------------------------------------
  // reset release and strap capture
  // ----------------------------------------
  // high through presetn and for the first edge after release; straps
  // are caught from a clocked process, never by the async reset itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_pulse <= 1'b1;
    end else begin
      reset_pulse <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_d3cold <= 1'b0;
      cap_d1 <= 1'b0;
      cap_d2 <= 1'b0;
    end else if (reset_pulse) begin
      cap_d3cold <= wake_d3cold_strap;
      cap_d1 <= d1_support_strap;
      cap_d2 <= d2_support_strap;
    end
  end

  // sticky bits only fall with presetn when cold wake is not offered
  assign zero_sticky = reset_pulse & ~wake_d3cold_strap;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready;
  assign wr_done = access_done & pwrite;

  always_comb begin
    hit_power_mgmt_control_status = 1'b0;
    hit_cap = 1'b0;
    hit_irq_status = 1'b0;
    hit_irq_mask = 1'b0;
    if (paddr == power_mgmt_control_status_pkg::OFF_POWER_MGMT_CONTROL_STATUS) begin
      hit_power_mgmt_control_status = 1'b1;
    end else if (paddr == power_mgmt_control_status_pkg::OFF_PWR_CAP) begin
      hit_cap = 1'b1;
    end else if (paddr == power_mgmt_control_status_pkg::OFF_IRQ_STATUS) begin
      hit_irq_status = 1'b1;
    end else if (paddr == power_mgmt_control_status_pkg::OFF_IRQ_MASK) begin
      hit_irq_mask = 1'b1;
    end
  end

  assign addr_ok = hit_power_mgmt_control_status | hit_cap | hit_irq_status | hit_irq_mask;

  // zero wait states: pready rises in the access cycle itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_phase;
      pslverr <= setup_phase & ~addr_ok;
    end
  end

  // ----------------------------------------
  // power state write check
  // ----------------------------------------
  assign wr_power_mgmt_control_status = wr_done & hit_power_mgmt_control_status;
  assign wr_power_mgmt_control_status_lo = wr_power_mgmt_control_status & pstrb[0];
  assign wr_power_mgmt_control_status_hi = wr_power_mgmt_control_status & pstrb[1];
  assign req_state = pwdata[power_mgmt_control_status_pkg::PSTATE_LSB +: power_mgmt_control_status_pkg::PSTATE_W];

  always_comb begin
    req_state_ok = 1'b1;
    if (req_state == power_mgmt_control_status_pkg::PSTATE_D1) begin
      req_state_ok = cap_d1;
    end else if (req_state == power_mgmt_control_status_pkg::PSTATE_D2) begin
      req_state_ok = cap_d2;
    end
  end

  // a rejected state drops the whole write, enable and clear included
  assign state_reject = wr_power_mgmt_control_status_lo & ~req_state_ok;
  assign power_mgmt_control_status_accept = wr_power_mgmt_control_status & ~state_reject;
  assign state_change = power_mgmt_control_status_accept & pstrb[0] & (req_state != power_state);

  // ----------------------------------------
  // power state
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_state <= power_mgmt_control_status_pkg::PSTATE_D0;
    end else if (power_mgmt_control_status_accept && pstrb[0]) begin
      power_state <= req_state;
    end
  end

  // ----------------------------------------
  // wake status and enable
  // ----------------------------------------
  assign wake_clear = power_mgmt_control_status_accept & pstrb[1] & pwdata[power_mgmt_control_status_pkg::WAKE_STATUS_BIT];

  // held by the auxiliary reset so it can survive presetn
  power_mgmt_control_status_sticky_bits #(
    .W(1)
  ) u_wake_status (
    .clk(pclk),
    .rst_n(aux_por_n),
    .set(wake_event),
    .clr(wake_clear),
    .zero(zero_sticky),
    .q(wake_event_status)
  );

  always_ff @(posedge pclk or negedge aux_por_n) begin
    if (!aux_por_n) begin
      wake_event_enable <= 1'b0;
    end else if (zero_sticky) begin
      wake_event_enable <= 1'b0;
    end else if (power_mgmt_control_status_accept && pstrb[1]) begin
      wake_event_enable <= pwdata[power_mgmt_control_status_pkg::WAKE_ENABLE_BIT];
    end
  end

  // pin follows status and enable with one flop of delay
  always_ff @(posedge pclk or negedge aux_por_n) begin
    if (!aux_por_n) begin
      wake_out_n <= 1'b1;
    end else begin
      wake_out_n <= ~(wake_event_status & wake_event_enable);
    end
  end

  // ----------------------------------------
  // interrupt status and mask
  // ----------------------------------------
  always_comb begin
    irq_set = '0;
    irq_set[power_mgmt_control_status_pkg::IRQ_WAKE_BIT] = wake_event;
    irq_set[power_mgmt_control_status_pkg::IRQ_STATE_BIT] = state_change;
    irq_set[power_mgmt_control_status_pkg::IRQ_REJECT_BIT] = state_reject;
  end

  always_comb begin
    irq_clr = '0;
    if (wr_done && hit_irq_status && pstrb[0]) begin
      irq_clr = pwdata[power_mgmt_control_status_pkg::IRQ_W-1:0];
    end
  end

  power_mgmt_control_status_sticky_bits #(
    .W(power_mgmt_control_status_pkg::IRQ_W)
  ) u_irq_status (
    .clk(pclk),
    .rst_n(presetn),
    .set(irq_set),
    .clr(irq_clr),
    .zero(1'b0),
    .q(irq_status)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= power_mgmt_control_status_pkg::IRQ_MASK_RESET;
    end else if (wr_done && hit_irq_mask && pstrb[0]) begin
      irq_mask <= pwdata[power_mgmt_control_status_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // ----------------------------------------
  // read views
  // ----------------------------------------
  // no data register here, so scale and select always read as zero
  always_comb begin
    power_mgmt_control_status_view = '0;
    power_mgmt_control_status_view[power_mgmt_control_status_pkg::WAKE_STATUS_BIT] = wake_event_status;
    power_mgmt_control_status_view[power_mgmt_control_status_pkg::SCALE_LSB +: power_mgmt_control_status_pkg::SCALE_W] = power_mgmt_control_status_pkg::SCALE_NONE;
    power_mgmt_control_status_view[power_mgmt_control_status_pkg::SELECT_LSB +: power_mgmt_control_status_pkg::SELECT_W] = power_mgmt_control_status_pkg::SELECT_NONE;
    power_mgmt_control_status_view[power_mgmt_control_status_pkg::WAKE_ENABLE_BIT] = wake_event_enable;
    power_mgmt_control_status_view[power_mgmt_control_status_pkg::PSTATE_LSB +: power_mgmt_control_status_pkg::PSTATE_W] = power_state;
  end

  always_comb begin
    cap_view = '0;
    cap_view[power_mgmt_control_status_pkg::CAP_D3COLD_BIT] = cap_d3cold;
    cap_view[power_mgmt_control_status_pkg::CAP_D2_BIT] = cap_d2;
    cap_view[power_mgmt_control_status_pkg::CAP_D1_BIT] = cap_d1;
  end

  always_comb begin
    next_prdata = '0;
    if (hit_power_mgmt_control_status) begin
      next_prdata[15:0] = power_mgmt_control_status_view;
    end else if (hit_cap) begin
      next_prdata[15:0] = cap_view;
    end else if (hit_irq_status) begin
      next_prdata[power_mgmt_control_status_pkg::IRQ_W-1:0] = irq_status;
    end else if (hit_irq_mask) begin
      next_prdata[power_mgmt_control_status_pkg::IRQ_W-1:0] = irq_mask;
    end
  end

  // data is sampled in setup; a flag set during the access shows next read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (setup_phase && !pwrite) begin
      prdata <= next_prdata;
    end
  end

endmodule

`default_nettype wire

/* File: test/power_mgmt_control_status_props.sv */
// port checks of the power management control/status bank
// assumes one clock domain and apb requests held through access
`timescale 1ns/1ps
`default_nettype none
module power_mgmt_control_status_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [power_mgmt_control_status_pkg::ADDR_W-1:0] paddr,
  input wire logic [power_mgmt_control_status_pkg::DATA_W-1:0] pwdata,
  input wire logic [power_mgmt_control_status_pkg::STRB_W-1:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic d1_support_strap,
  input wire logic wake_event,
  input wire logic wake_out_n,
  input wire logic [power_mgmt_control_status_pkg::PSTATE_W-1:0] power_state
);
  logic wr0;
  assign wr0 = psel && penable && pready && pwrite && paddr == power_mgmt_control_status_pkg::OFF_POWER_MGMT_CONTROL_STATUS;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_setup: assert property (psel && !penable |=> pready && penable)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  a_err_range: assert property (pslverr |-> pready && paddr != power_mgmt_control_status_pkg::OFF_POWER_MGMT_CONTROL_STATUS &&
    paddr != power_mgmt_control_status_pkg::OFF_PWR_CAP && paddr != power_mgmt_control_status_pkg::OFF_IRQ_STATUS &&
    paddr != power_mgmt_control_status_pkg::OFF_IRQ_MASK)
    else $error("bad error response");
  a_state_take: assert property (
    wr0 && pstrb[0] && pwdata[0] == pwdata[1] |=> power_state == $past(pwdata[1:0]))
    else $error("state not taken");
  a_state_reject: assert property (
    wr0 && pstrb[0] && pwdata[1:0] == 2'h1 && !d1_support_strap |=> $stable(power_state))
    else $error("unsupported state taken");
  // flag or enable changes at the write edge, the pin one edge later
  a_clear_pin: assert property (
    wr0 && pstrb[1] && pwdata[15] && (pwdata[0] == pwdata[1] || !pstrb[0]) &&
    !wake_event |-> ##2 wake_out_n)
    else $error("pin kept after clear");
  a_enable_pin: assert property (
    wr0 && pstrb[1] && !pwdata[8] && (pwdata[0] == pwdata[1] || !pstrb[0])
    |-> ##2 wake_out_n)
    else $error("pin while disabled");
  a_pin_cause: assert property (
    $fell(wake_out_n) |-> $past(wake_event, 2) || $past(wr0 && pwdata[8], 2))
    else $error("pin without cause");
endmodule
`default_nettype wire

/* File: test/power_mgmt_control_status_host_model.sv */
// configuration software side: an apb master issuing one transfer per call
// assumes calls made from a procedure synchronised to pclk
`timescale 1ns/1ps
`default_nettype none
module power_mgmt_control_status_host_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
  end
  // leading edge wait keeps back-to-back calls from double driving
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pstrb <= s;
    pwdata <= (a == 12'h000) ? (d & 32'hFFFF_FF03) : d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: test/tb.sv */
// self-checking bench of the power management control/status bank
// assumes the host model for all register traffic
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic aux_por_n = 1'b0;
  logic d3c = 1'b1;
  logic d1s = 1'b0;
  logic d2s = 1'b1;
  logic wake_event = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, wake_out_n, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [3:0] pstrb;
  logic [1:0] power_state;
  int fails = 0;
  int n_tests = 0;
  always #20 pclk = ~pclk;
  power_mgmt_control_status_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
    .prdata(prdata));
  power_mgmt_control_status_ctrl uut (.pclk(pclk), .presetn(presetn), .aux_por_n(aux_por_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .wake_d3cold_strap(d3c),
    .d1_support_strap(d1s), .d2_support_strap(d2s), .wake_event(wake_event),
    .wake_out_n(wake_out_n), .power_state(power_state), .irq(irq));
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, 4'hF, rdata, err);
  endtask
  task automatic wr_lanes(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    host.xfer(1'b1, a, d, s, rdata, err);
  endtask
  task automatic rd(input logic [11:0] a);
    host.xfer(1'b0, a, 32'h0, 4'hF, rdata, err);
  endtask
  task automatic do_reset(input logic aux);
    @(posedge pclk);
    presetn <= 1'b0;
    aux_por_n <= !aux;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    aux_por_n <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask
  task automatic pulse();
    @(posedge pclk);
    wake_event <= 1'b1;
    @(posedge pclk);
    wake_event <= 1'b0;
  endtask
  task automatic t_regs();
    rd(power_mgmt_control_status_pkg::OFF_POWER_MGMT_CONTROL_STATUS); chk("ctrl", rdata, 32'h0);
    rd(power_mgmt_control_status_pkg::OFF_PWR_CAP); chk("caps", rdata, 32'h0000_8400);
    rd(12'h010); chk("unmapped", rdata, 32'h0);
    chk("unmapped err", 32'(err), 32'h1);
    $display("regs done");
  endtask
  task automatic t_state();
    logic [1:0] cur;
    cur = 2'h0;
    for (int s = 0; s < 4; s++) begin
      wr(power_mgmt_control_status_pkg::OFF_POWER_MGMT_CONTROL_STATUS, 32'h0000_7E00 | 32'(s));
      if (s != 1) cur = 2'(s);
      rd(power_mgmt_control_status_pkg::OFF_POWER_MGMT_CONTROL_STATUS); chk("state", rdata, {30'h0, cur});
      chk("state pin", {30'h0, power_state}, {30'h0, cur});
    end
    // one rejected write and changes to D2 and D3hot, irq mask still closed
    rd(power_mgmt_control_status_pkg::OFF_IRQ_STATUS); chk("irq events", rdata, 32'h6);
    chk("irq masked", 32'(irq), 32'h0);
    wr(power_mgmt_control_status_pkg::OFF_POWER_MGMT_CONTROL_STATUS, 32'h0);
    $display("state done");
  endtask
  task automatic t_wake();
    wr(power_mgmt_control_status_pkg::OFF_IRQ_STATUS, 32'h7);
    wr(power_mgmt_control_status_pkg::OFF_IRQ_MASK, 32'h1);
    pulse();
    rd(power_mgmt_control_status_pkg::OFF_POWER_MGMT_CONTROL_STATUS); chk("status", rdata, 32'h8000);
    chk("pin off", 32'(wake_out_n), 32'h1);
    chk("irq", 32'(irq), 32'h1);
    wr(power_mgmt_control_status_pkg::OFF_POWER_MGMT_CONTROL_STATUS, 32'h100);
    rd(power_mgmt_control_status_pkg::OFF_POWER_MGMT_CONTROL_STATUS); chk("zero keeps", rdata, 32'h8100);
    chk("pin on", 32'(wake_out_n), 32'h0);
    wr_lanes(power_mgmt_control_status_pkg::OFF_POWER_MGMT_CONTROL_STATUS, 32'h8000, 4'h1);
    rd(power_mgmt_control_status_pkg::OFF_POWER_MGMT_CONTROL_STATUS); chk("lane kept", rdata, 32'h8100);
    wr(power_mgmt_control_status_pkg::OFF_POWER_MGMT_CONTROL_STATUS, 32'h8100);
    rd(power_mgmt_control_status_pkg::OFF_POWER_MGMT_CONTROL_STATUS); chk("one clears", rdata, 32'h100);
    chk("pin free", 32'(wake_out_n), 32'h1);
    wr(power_mgmt_control_status_pkg::OFF_IRQ_STATUS, 32'h1);
    rd(power_mgmt_control_status_pkg::OFF_IRQ_STATUS); chk("irq clear", {rdata[31:1], irq}, 32'h0);
    pulse();
    $display("wake done");
  endtask
  task automatic t_sticky();
    do_reset(1'b0);
    rd(power_mgmt_control_status_pkg::OFF_POWER_MGMT_CONTROL_STATUS); chk("sticky", rdata, 32'h8100);
    chk("sticky pin", 32'(wake_out_n), 32'h0);
    d3c <= 1'b0;
    d1s <= 1'b1;
    d2s <= 1'b0;
    do_reset(1'b0);
    rd(power_mgmt_control_status_pkg::OFF_POWER_MGMT_CONTROL_STATUS); chk("zeroed", rdata, 32'h0);
    rd(power_mgmt_control_status_pkg::OFF_PWR_CAP); chk("caps cold", rdata, 32'h0000_0200);
    wr(power_mgmt_control_status_pkg::OFF_POWER_MGMT_CONTROL_STATUS, 32'h1);
    rd(power_mgmt_control_status_pkg::OFF_POWER_MGMT_CONTROL_STATUS); chk("d1 taken", rdata, 32'h1);
    wr(power_mgmt_control_status_pkg::OFF_POWER_MGMT_CONTROL_STATUS, 32'h2);
    rd(power_mgmt_control_status_pkg::OFF_POWER_MGMT_CONTROL_STATUS); chk("d2 refused", rdata, 32'h1);
    $display("sticky done");
  endtask
  task automatic give_verdict();
    $display("tests %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    do_reset(1'b1);
    // software clears the sticky wake bits at load
    wr(power_mgmt_control_status_pkg::OFF_POWER_MGMT_CONTROL_STATUS, 32'h8000);
    t_regs();
    t_state();
    t_wake();
    t_sticky();
    give_verdict();
  end
  initial begin
    repeat (3000) @(posedge pclk);
    fails++;
    give_verdict();
  end
endmodule
bind power_mgmt_control_status_ctrl power_mgmt_control_status_props chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pready(pready), .pslverr(pslverr), .d1_support_strap(d1_support_strap),
  .wake_event(wake_event), .wake_out_n(wake_out_n), .power_state(power_state));
`default_nettype wire
